// >>> src/muldiv_pkg.sv
// Constants, encodings and the register map of the coprocessor arithmetic unit.
package muldiv_pkg;
  localparam int          REG_COUNT        = 16;
  localparam logic [3:0]  IDX_A_LOW        = 4'h0;
  localparam logic [3:0]  IDX_D_HIGH       = 4'h7;
  localparam logic [3:0]  IDX_MODE         = 4'h8;
  localparam logic [3:0]  IDX_STATUS       = 4'h9;
  localparam logic [3:0]  IDX_UNUSED_FIRST = 4'hA;
  localparam logic [3:0]  IDX_UNUSED_LAST  = 4'hE;
  localparam logic [3:0]  IDX_IDENT        = 4'hF;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  // Mode register fields.
  localparam int          MODE_OP_LSB      = 0;
  localparam int          MODE_OP_W        = 3;
  localparam int          MODE_SIGNED_BIT  = 3;
  localparam int          MODE_ENABLE_BIT  = 7;
  // Status register fields.
  localparam int          STAT_BUSY_BIT    = 0;
  localparam int          STAT_DONE_BIT    = 1;
  localparam int          STAT_DIVZ_BIT    = 2;
  localparam int          STAT_SAT_BIT     = 3;
  localparam int          STAT_ZERO_BIT    = 4;
  localparam int          STAT_NEG_BIT     = 5;
  // Operation time in cycles.
  localparam int          CYC_MUL          = 4;
  localparam int          CYC_DIV16        = 8;
  localparam int          CYC_DIV32        = 16;
  localparam int          CYC_MAC          = 4;
  localparam logic [31:0] SAT_POS          = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG          = 32'h8000_0000;
  localparam logic [31:0] ZERO32           = 32'h0000_0000;
  typedef enum logic [2:0] {
    OP_MUL    = 3'h0,
    OP_DIV16  = 3'h1,
    OP_DIV32  = 3'h2,
    OP_MAC    = 3'h3,
    OP_MACSAT = 3'h4
  } op_t;
endpackage

// >>> src/arith_if.sv
// Operand and result carrier between the register bank and the arithmetic core.
`timescale 1ns/100ps
interface arith_if;
  import muldiv_pkg::*;
  logic        start;
  logic [2:0]  op;
  logic        signed_mode;
  logic [63:0] operands;
  logic        done;
  logic [63:0] result;
  logic        div_zero;
  logic        saturated;
  modport bank (output start, op, signed_mode, operands, input done, result, div_zero, saturated);
  modport core (input start, op, signed_mode, operands, output done, result, div_zero, saturated);
endinterface

// >>> src/arith_core.sv
// Arithmetic core: multiply, divide and multiply-accumulate with fixed latency.
`timescale 1ns/100ps
module arith_core
  import muldiv_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  arith_if.core     aif
);
  logic [4:0]  count_q;
  logic        busy_q;
  logic [63:0] res_q;
  logic        divz_q;
  logic        sat_q;
  logic [2:0]  op_q;
  logic [4:0]  latency;
  logic [15:0] a16;
  logic [15:0] b16;
  logic [15:0] c16;
  logic [15:0] d16;
  logic [31:0] ab32;
  logic [31:0] cd32;
  logic        sg;
  logic signed [33:0] prod;
  logic signed [34:0] mac_sum;
  logic [31:0] prod32;
  logic [31:0] mac32;
  logic        mac_ovf;
  logic [31:0] sat32;
  logic [31:0] dvd_mag;
  logic [31:0] dvs_mag;
  logic [31:0] q_mag;
  logic [31:0] r_mag;
  logic        dvd_neg;
  logic        dvs_neg;
  logic [31:0] quot;
  logic [31:0] rem;
  logic        dz;
  logic [63:0] res_d;

  assign a16  = aif.operands[15:0];
  assign b16  = aif.operands[31:16];
  assign c16  = aif.operands[47:32];
  assign d16  = aif.operands[63:48];
  assign ab32 = aif.operands[31:0];
  assign cd32 = aif.operands[63:32];
  assign sg   = aif.signed_mode;
  // Sign bit taken from each operand's top bit when signed.
  assign prod = $signed({sg & d16[15], d16}) * $signed({sg & c16[15], c16});
  assign prod32 = prod[31:0];
  assign mac_sum = 35'(prod) + $signed({{3{sg & ab32[31]}}, ab32});
  assign mac32 = mac_sum[31:0];
  assign mac_ovf = sg ? (mac_sum[34:31] != {4{mac_sum[31]}}) : (mac_sum[34:32] != 3'h0);
  // Unsigned overflow can only go upward, so it clamps to all ones of the range.
  assign sat32 = sg ? (mac_sum[34] ? SAT_NEG : SAT_POS) : 32'hFFFF_FFFF;
  assign dvd_neg = sg & ab32[31];
  assign dvs_neg = (aif.op == OP_DIV16) ? (sg & d16[15]) : (sg & cd32[31]);
  assign dvd_mag = dvd_neg ? 32'(-ab32) : ab32;
  assign dvs_mag = (aif.op == OP_DIV16) ? (dvs_neg ? {16'h0000, 16'(-d16)} : {16'h0000, d16})
                                        : (dvs_neg ? 32'(-cd32) : cd32);
  assign dz    = (dvs_mag == ZERO32);
  assign q_mag = dz ? 32'hFFFF_FFFF : dvd_mag / dvs_mag;
  assign r_mag = dz ? dvd_mag : dvd_mag % dvs_mag;
  assign quot  = (dvd_neg ^ dvs_neg) ? 32'(-q_mag) : q_mag;
  assign rem   = dvd_neg ? 32'(-r_mag) : r_mag;
  // Results land in the documented slots, untouched slots keep the operands.
  assign res_d = (aif.op == OP_DIV16) ? {d16, rem[15:0], quot} :
                 (aif.op == OP_DIV32) ? {rem, quot} :
                 (aif.op == OP_MAC) ? {cd32, mac32} :
                 (aif.op == OP_MACSAT) ? {cd32, (mac_ovf ? sat32 : mac32)} :
                 {cd32, prod32};
  assign latency = (aif.op == OP_DIV16) ? 5'(CYC_DIV16) :
                   (aif.op == OP_DIV32) ? 5'(CYC_DIV32) :
                   (aif.op == OP_MUL) ? 5'(CYC_MUL) : 5'(CYC_MAC);
  // The answer is computed at start and held back to honour the fixed latency.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_q <= 5'h00;
      busy_q  <= 1'b0;
      res_q   <= 64'h0;
      divz_q  <= 1'b0;
      sat_q   <= 1'b0;
      op_q    <= 3'h0;
    end
    else if (aif.start)
    begin
      count_q <= latency - 5'h01;
      busy_q  <= 1'b1;
      res_q   <= res_d;
      divz_q  <= dz & ((aif.op == OP_DIV16) | (aif.op == OP_DIV32));
      sat_q   <= mac_ovf & (aif.op == OP_MACSAT);
      op_q    <= aif.op;
    end
    else if (busy_q)
    begin
      count_q <= count_q - 5'h01;
      busy_q  <= (count_q != 5'h01);
    end
  end
  assign aif.done      = busy_q & (count_q == 5'h01);
  assign aif.result    = res_q;
  assign aif.div_zero  = divz_q;
  assign aif.saturated = sat_q;
endmodule

// >>> src/coproc_muldiv.sv
// Top of the coprocessor arithmetic unit: byte register bank and access port.
`timescale 1ns/100ps
module coproc_muldiv
  import muldiv_pkg::*;
#(
  parameter logic [7:0] UNIT_ID = 8'h5A  // Arbitrary identification value.
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cop_wr,
  input  wire logic        cop_rd,
  input  wire logic [3:0]  cop_addr,
  input  wire logic [1:0]  cop_size,
  input  wire logic [63:0] cop_wdata,
  output logic [63:0]      cop_rdata,
  output logic             busy
);
  // cop_size: 0 byte, 1 word, 2 double word, 3 quad word; addr aligned to size.
  arith_if aif ();
  logic [7:0]  bank_q [REG_COUNT];
  logic [7:0]  bank_d [REG_COUNT];
  logic [7:0]  rd_byte [REG_COUNT];
  logic [15:0] byte_hit;
  logic [3:0]  span;
  logic        start_hit;
  logic        run_q;
  logic [63:0] rdata_d;
  logic [63:0] rdata_q;
  logic [7:0]  status_d;

  assign span = 4'((5'h01 << cop_size)) - 4'h1;
  assign start_hit = cop_wr & byte_hit[IDX_D_HIGH] & bank_q[IDX_MODE][MODE_ENABLE_BIT];
  assign aif.start = start_hit;
  assign aif.op = bank_q[IDX_MODE][MODE_OP_LSB +: MODE_OP_W];
  assign aif.signed_mode = bank_q[IDX_MODE][MODE_SIGNED_BIT];
  // Operands include the byte being written now, so the start sees it.
  assign aif.operands = {bank_d[7], bank_d[6], bank_d[5], bank_d[4],
                         bank_d[3], bank_d[2], bank_d[1], bank_d[0]};
  assign status_d = {2'b00, aif.result[31], (aif.result[31:0] == ZERO32),
                     aif.saturated, aif.div_zero, 1'b1, 1'b0};

  genvar i;
  generate
    for (i = 0; i < REG_COUNT; i++)
    begin : g_byte
      logic [3:0] rel;
      assign rel = 4'(i) - cop_addr;
      // Grouped access covers consecutive bytes together.
      assign byte_hit[i] = (4'(i) >= cop_addr) && (rel <= span);
      always_comb
      begin
        bank_d[i] = bank_q[i];
        if (cop_wr && byte_hit[i])
          bank_d[i] = cop_wdata[8*rel +: 8];
      end
      // Unused slots read zero; identifier is fixed.
      assign rd_byte[i] = (4'(i) == IDX_IDENT) ? UNIT_ID :
                          (4'(i) >= IDX_UNUSED_FIRST) ? BYTE_RESET : bank_q[i];
      if (i < 8)
      begin : g_operand
        always_ff @(posedge clk)
        begin
          if (reset)
            bank_q[i] <= BYTE_RESET;
          else if (aif.done)
            bank_q[i] <= aif.result[8*i +: 8];
          else
            bank_q[i] <= bank_d[i];
        end
      end
      else if (i == 8)
      begin : g_mode
        always_ff @(posedge clk)
        begin
          if (reset)
            bank_q[i] <= BYTE_RESET;
          else
            bank_q[i] <= bank_d[i];
        end
      end
      else if (i == 9)
      begin : g_status
        // Completion wins over a software write in the same cycle.
        always_ff @(posedge clk)
        begin
          if (reset)
            bank_q[i] <= BYTE_RESET;
          else if (aif.done)
            bank_q[i] <= status_d;
          else if (start_hit)
            bank_q[i] <= 8'h01;
          else
            bank_q[i] <= bank_d[i];
        end
      end
      else
      begin : g_none
        assign bank_q[i] = BYTE_RESET;
      end
    end
  endgenerate

  always_comb
  begin
    rdata_d = 64'h0;
    for (int k = 0; k < 8; k++)
      if (4'(k) <= span)
        rdata_d[8*k +: 8] = rd_byte[4'(cop_addr + 4'(k))];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q <= 64'h0;
      run_q   <= 1'b0;
    end
    else
    begin
      if (cop_rd)
        rdata_q <= rdata_d;
      run_q <= start_hit | (run_q & ~aif.done);
    end
  end
  // Reads during a run return operands until the result lands.
  assign cop_rdata = rdata_q;
  assign busy = run_q;

  arith_core u_core (
    .clk   (clk),
    .reset (reset),
    .aif   (aif.core)
  );
endmodule

// >>> tb/coproc_muldiv_assertions.sv
// Timing and read-back checks on the ports of the arithmetic unit.
`timescale 1ns/100ps
module coproc_muldiv_assertions
  import muldiv_pkg::*;
#(
  parameter logic [7:0] UNIT_ID = 8'h5A
)
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cop_wr,
  input wire logic        cop_rd,
  input wire logic [3:0]  cop_addr,
  input wire logic [1:0]  cop_size,
  input wire logic [63:0] cop_wdata,
  input wire logic [63:0] cop_rdata,
  input wire logic        busy
);
  logic       en_q;
  logic [2:0] op_q;
  logic [5:0] cnt_q;
  logic [5:0] need;
  logic [3:0] last;
  logic       hit7;
  logic       start;
  assign last  = cop_addr + ((4'h1 << cop_size) - 4'h1);
  assign hit7  = cop_wr && (last == IDX_D_HIGH) && !busy;
  assign start = hit7 && en_q;
  assign need  = (op_q == OP_DIV16) ? 6'h8 : (op_q == OP_DIV32) ? 6'h10 : 6'h4;
  // Mode is tracked here only from writes that begin at the mode byte.
  always_ff @(posedge clk)
  begin
    en_q  <= reset ? 1'h0 : (cop_wr && cop_addr == IDX_MODE) ? cop_wdata[7] : en_q;
    op_q  <= reset ? 3'h0 : (cop_wr && cop_addr == IDX_MODE) ? cop_wdata[2:0] : op_q;
    cnt_q <= (reset || start) ? 6'h0 : busy ? cnt_q + 6'h1 : cnt_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Busy rises on the edge after the starting write and drops on the edge
  // that lands the result, so a four-cycle operation shows busy for three samples.
  sequence short_run_s;
    busy [*3] ##1 !busy;
  endsequence
  reset_clear_a: assert property (disable iff (1'h0) reset |=> cop_rdata == 64'h0 && !busy)
    else $error("outputs not cleared by reset");
  start_busy_a: assert property (start |=> busy)
    else $error("start did not raise busy");
  no_enable_a: assert property (hit7 && !en_q |=> !busy)
    else $error("disabled unit started");
  busy_bound_a: assert property (busy |-> cnt_q <= need)
    else $error("operation ran too long");
  busy_fall_a: assert property ($fell(busy) |-> cnt_q == need - 6'h1)
    else $error("operation length wrong");
  short_run_a: assert property (start && op_q != OP_DIV16 && op_q != OP_DIV32 |=> short_run_s)
    else $error("short operation length wrong");
  unused_zero_a: assert property (cop_rd && cop_size == 2'h0 && cop_addr >= IDX_UNUSED_FIRST
    && cop_addr <= IDX_UNUSED_LAST |=> cop_rdata == 64'h0)
    else $error("unused byte not zero");
  ident_read_a: assert property (cop_rd && cop_size == 2'h0 && cop_addr == IDX_IDENT
    |=> cop_rdata == 64'(UNIT_ID))
    else $error("identifier wrong");
  rdata_hold_a: assert property (!cop_rd |=> $stable(cop_rdata))
    else $error("read data moved");
  upper_zero_a: assert property (cop_rd && cop_size == 2'h0 |=> cop_rdata[63:8] == 56'h0)
    else $error("upper read bytes not zero");
endmodule
bind coproc_muldiv coproc_muldiv_assertions #(.UNIT_ID(UNIT_ID)) u_chk (.clk(clk), .reset(reset),
  .cop_wr(cop_wr), .cop_rd(cop_rd), .cop_addr(cop_addr), .cop_size(cop_size),
  .cop_wdata(cop_wdata), .cop_rdata(cop_rdata), .busy(busy));

// >>> tb/host_cpu.sv
// Host model that issues coprocessor transfers to the unit.
`timescale 1ns/100ps
module host_cpu
(
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [63:0] cop_rdata,
  output logic             cop_wr = 1'h0,
  output logic             cop_rd = 1'h0,
  output logic [3:0]       cop_addr = 4'h0,
  output logic [1:0]       cop_size = 2'h0,
  output logic [63:0]      cop_wdata = 64'h0
);
  // Only transfers reach the unit; there is no memory-mapped path.
  task automatic put(input logic [3:0] a, input logic [1:0] s, input logic [63:0] d);
    @(posedge clk);
    cop_wr    <= 1'h1;
    cop_addr  <= a;
    cop_size  <= s;
    cop_wdata <= d;
    @(posedge clk);
    cop_wr    <= 1'h0;
    cop_wdata <= ~d;
  endtask
  task automatic get(input logic [3:0] a, input logic [1:0] s, output logic [63:0] d);
    @(posedge clk);
    cop_rd   <= 1'h1;
    cop_addr <= a;
    cop_size <= s;
    @(posedge clk);
    cop_rd   <= 1'h0;
    @(posedge clk);
    d = cop_rdata;
  endtask
  // Polling busy keeps a slow divide from being read half done.
  task automatic wait_idle(output logic ok);
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clk);
      ok = (busy === 1'h0);
    end
  endtask
endmodule

// >>> tb/coproc_muldiv_bench.sv
// Self-checking bench for the coprocessor arithmetic unit.
`timescale 1ns/100ps
module coproc_muldiv_bench
  import muldiv_pkg::*;
;
  typedef struct packed {logic [2:0] op; logic sgn; logic [63:0] opnd; logic [63:0] res;} case_t;
  localparam logic [7:0] ID = 8'h3C;  // Arbitrary identification value.
  case_t       tbl [12] = '{
    '{OP_MUL, 1'h0, 64'hFFFF_0002_0000_0000, 64'h0001_FFFE},
    '{OP_MUL, 1'h1, 64'hFFFF_0002_0000_0000, 64'hFFFF_FFFE},
    '{OP_DIV16, 1'h0, 64'h0007_0000_0000_0064, 64'h0002_0000_000E},
    '{OP_DIV16, 1'h1, 64'h0007_0000_FFFF_FF9C, 64'hFFFE_FFFF_FFF2},
    '{OP_DIV16, 1'h0, 64'h0000_0000_0000_1234, 64'h1234_FFFF_FFFF},
    '{OP_DIV32, 1'h0, 64'h0001_0000_0003_0005, 64'h0000_0005_0000_0003},
    '{OP_DIV32, 1'h1, 64'h0001_0000_FFFC_FFFB, 64'hFFFF_FFFB_FFFF_FFFD},
    '{OP_MAC, 1'h0, 64'h0005_0003_0000_0010, 64'h1F},
    '{OP_MAC, 1'h1, 64'h0005_FFFF_0000_0010, 64'hB},
    '{OP_MACSAT, 1'h1, 64'h7FFF_7FFF_7FFF_FFF0, 64'h7FFF_FFFF},
    '{OP_MACSAT, 1'h1, 64'h8000_7FFF_8000_0010, 64'h8000_0000},
    '{OP_MACSAT, 1'h0, 64'h0010_0010_FFFF_FFF0, 64'hFFFF_FFFF}};
  logic        clk;
  logic        reset = 1'h1;
  logic        cop_wr, cop_rd, busy, ok;
  logic [3:0]  cop_addr;
  logic [1:0]  cop_size;
  logic [63:0] cop_wdata, cop_rdata, rd, m;
  logic [7:0]  st;
  int          fail_count = 0;
  int          checks = 0;
  coproc_muldiv #(.UNIT_ID(ID)) u_dut (.clk(clk), .reset(reset), .cop_wr(cop_wr),
    .cop_rd(cop_rd), .cop_addr(cop_addr), .cop_size(cop_size), .cop_wdata(cop_wdata),
    .cop_rdata(cop_rdata), .busy(busy));
  host_cpu u_host (.clk(clk), .busy(busy), .cop_rdata(cop_rdata), .cop_wr(cop_wr),
    .cop_rd(cop_rd), .cop_addr(cop_addr), .cop_size(cop_size), .cop_wdata(cop_wdata));
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // The span covers every table entry several times over.
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    u_host.get(IDX_A_LOW, 2'h3, rd);
    check("operands", 64'h0, rd);
    u_host.get(IDX_MODE, 2'h3, rd);
    check("upper bank", {ID, 56'h0}, rd);
    u_host.put(IDX_MODE, 2'h3, 64'hFFFF_FFFF_FFFF_FF00);
    u_host.get(IDX_MODE, 2'h3, rd);
    check("upper write", {ID, 40'h0, 16'hFF00}, rd);
    u_host.put(IDX_A_LOW, 2'h3, 64'h1111_2222_3333_4444);
    u_host.get(IDX_A_LOW, 2'h3, rd);
    check("disabled", 64'h1111_2222_3333_4444, rd);
    check("busy", 64'h0, 64'(busy));
    foreach (tbl[i])
    begin
      u_host.put(IDX_MODE, 2'h0, {56'h0, 1'h1, 3'h0, tbl[i].sgn, tbl[i].op});
      u_host.put(IDX_A_LOW, 2'h3, tbl[i].opnd);
      u_host.wait_idle(ok);
      check("idle", 64'h1, 64'(ok));
      m = tbl[i].op == OP_DIV16 ? 64'hFFFF_FFFF_FFFF : tbl[i].op == OP_DIV32 ? '1 : 64'hFFFF_FFFF;
      u_host.get(IDX_A_LOW, 2'h3, rd);
      check("result", tbl[i].res, rd & m);
      st = {2'h0, tbl[i].res[31], tbl[i].res[31:0] == 32'h0, tbl[i].op == OP_MACSAT,
        tbl[i].op == OP_DIV16 && tbl[i].opnd[63:48] == 16'h0, 2'h2};
      u_host.get(IDX_STATUS, 2'h0, rd);
      check("status", 64'(st), rd);
    end
    u_host.put(4'h4, 2'h1, 64'hABCD);
    u_host.get(4'h5, 2'h0, rd);
    check("word byte", 64'hAB, rd);
    u_host.get(IDX_MODE, 2'h0, rd);
    check("mode", 64'h84, rd);
    print_verdict();
  end
endmodule
